// ===== watchdog_regs.svh
`ifndef WATCHDOG_REGS_SVH
`define WATCHDOG_REGS_SVH

// ****************************************************************
// special function register addresses
// ****************************************************************
`define WDT_CONTROL_ADDR   8'ha5
`define WDT_COUNT_ADDR     8'hff

// ****************************************************************
// reset values and control codes
// ****************************************************************
`define WDT_CONTROL_RESET  8'ha5
`define WDT_COUNT_RESET    8'h00
`define WDT_HALT_VALUE     8'ha5
`define WDT_UNLOCK_VALUE   8'h5a
`define WDT_CLEARED_VALUE  8'h00

// ****************************************************************
// timing counts: prescaler in oscillator cycles, counter and pulse in prescaler wraps
// ****************************************************************
`define WDT_PRESCALE_LAST  11'h7ff
`define WDT_COUNT_LAST     8'hff
`define WDT_PULSE_LAST     4'hf

`endif

// ===== watchdog_pkg.sv
// ****************************************************************
// shared types
// ****************************************************************
package watchdog_pkg;

	// gray codes along halted -> run -> pulse
	typedef enum logic [1:0] {
		st_halted = 2'b00,
		st_run    = 2'b01,
		st_pulse  = 2'b11
	} wdt_state_type;

endpackage : watchdog_pkg

// ===== watchdog_tick_if.sv
`timescale 1ns/1ps
// ****************************************************************
// one-cycle tick per rising edge of the watchdog oscillator
// ****************************************************************
interface watchdog_tick_if;
	logic osc_tick;    // one clk_sys cycle per rising oscillator edge

	modport source (output osc_tick);
	modport sink   (input  osc_tick);
endinterface : watchdog_tick_if

// ===== watchdog_osc_sync.sv
`timescale 1ns/1ps
// ****************************************************************
// brings the free oscillator into clk_sys and finds its rising edge
// ****************************************************************
module watchdog_osc_sync (
	// clock and reset
	input  wire logic     clk_sys,
	input  wire logic     reset,
	// raw oscillator from the on-chip watchdog oscillator
	input  wire logic     wd_osc_raw,
	// tick towards the counter
	watchdog_tick_if.source tick_bus
);

	logic sync_first;    // metastable stage, read only by sync_second
	logic sync_second;   // settled copy
	logic sync_last;     // previous settled value for edge finding

	// two-flop synchroniser; the oscillator has no relation to clk_sys
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			sync_first  <= 1'b0;
			sync_second <= 1'b0;
		end else begin
			sync_first  <= wd_osc_raw;
			sync_second <= sync_first;
		end
	end

	// rising edge becomes a registered one-cycle tick
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			sync_last         <= 1'b0;
			tick_bus.osc_tick <= 1'b0;
		end else begin
			sync_last         <= sync_second;
			tick_bus.osc_tick <= sync_second & ~sync_last;
		end
	end

endmodule : watchdog_osc_sync

// ===== watchdog_timer_unit.sv
`timescale 1ns/1ps
`include "watchdog_regs.svh"
// Contract
// - 11-bit prescaler feeds 8-bit readable counter
// - prescaler clocked by own 1MHz oscillator
// - counting ignores main crystal clock once enabled
// - counter steps once per 2048 oscillator cycles
// - overflow resets chip, 16x2048 cycle pin pulse
// - internal reset ignores reset pin held low
// - reset forces ports 1-3 high, port 0 floating
// - control register at a5, read and write
// - control a5 stops oscillator, clears both counters; the reset pulse holds a5 with oscillator and prescaler running
// - any reset loads control with a5
// - any other control value enables counting
// - counter readable while running, never stopped
// - counter write accepted only with control 5a
// - accepted write clears prescaler and control
// - timeout is (256 - load) times 2048
// - watchdog reset ends power-down like external
module watchdog_timer_unit
	import watchdog_pkg::*;
(
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       reset,
	// watchdog oscillator
	input  wire logic       wd_osc_raw,
	output logic            osc_run,
	// special function register port
	input  wire logic [7:0] sfr_addr,
	input  wire logic [7:0] sfr_wdata,
	input  wire logic       sfr_wr,
	input  wire logic       sfr_rd,
	output logic      [7:0] sfr_rdata,
	// reset outputs
	output logic            chip_reset,
	output logic            rst_pin_out,
	output logic            rst_pin_oe,
	output logic            port123_force_high,
	output logic            port0_float,
	output logic            powerdown_exit
);

	// ****************************************************************
	// state and storage
	// ****************************************************************
	watchdog_tick_if tick_bus ();              // oscillator tick carrier

	wdt_state_type state;                     // halted, run or pulse
	wdt_state_type next_state;                // combinational next
	logic [7:0]    watchdog_control;          // a5 halts, 5a unlocks
	logic [7:0]    watchdog_count;            // software-visible count
	logic [10:0]   prescaler;                 // oscillator cycle count
	logic [3:0]    pulse_wraps;               // prescaler wraps in pulse
	logic          wrap;                      // prescaler at last value
	logic          write_control;             // decoded control write
	logic          write_count;               // decoded counter write
	logic          accept_write;              // unlocked counter write
	logic          overflow;                  // count ff -> 00

	// true when the written or held value is the halt code
	function automatic logic is_halt(input logic [7:0] value);
		return value == `WDT_HALT_VALUE;
	endfunction : is_halt

	// ****************************************************************
	// oscillator edge detection
	// ****************************************************************
	// the oscillator is separate from the crystal; clk_sys stays on
	watchdog_osc_sync osc_sync (
		.clk_sys    (clk_sys),
		.reset      (reset),
		.wd_osc_raw (wd_osc_raw),
		.tick_bus   (tick_bus)
	);

	// ****************************************************************
	// decode
	// ****************************************************************
	// address decode and the events that steer the state machine
	always_comb begin
		write_control = 1'b0;
		write_count   = 1'b0;
		if (sfr_wr && sfr_addr == `WDT_CONTROL_ADDR) begin
			write_control = (state != st_pulse);
		end else if (sfr_wr && sfr_addr == `WDT_COUNT_ADDR) begin
			write_count = (state != st_pulse);
		end
		// only the unlock value lets a counter write through
		accept_write = write_count &&
			watchdog_control == `WDT_UNLOCK_VALUE;
		wrap = tick_bus.osc_tick && prescaler == `WDT_PRESCALE_LAST;
		// a reload in the same cycle beats the overflow
		overflow = (state == st_run) && wrap && !accept_write &&
			watchdog_count == `WDT_COUNT_LAST;
	end

	// ****************************************************************
	// state machine
	// ****************************************************************
	// pulse ends after 16 prescaler wraps, then control is a5 again
	always_comb begin
		next_state = state;
		case (state)
			st_halted: begin
				if (write_control && !is_halt(sfr_wdata)) begin
					next_state = st_run;
				end
			end
			st_run: begin
				if (overflow) begin
					next_state = st_pulse;
				end else if (write_control && is_halt(sfr_wdata)) begin
					next_state = st_halted;
				end
			end
			st_pulse: begin
				if (wrap && pulse_wraps == `WDT_PULSE_LAST) begin
					next_state = st_halted;
				end
			end
			default: begin
				next_state = st_halted;
			end
		endcase
	end

	// state register
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state <= st_halted;
		end else begin
			state <= next_state;
		end
	end

	// ****************************************************************
	// control register
	// ****************************************************************
	// cleared by an accepted reload, which also relocks the counter
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			watchdog_control <= `WDT_CONTROL_RESET;
		end else if (next_state == st_pulse || state == st_pulse) begin
			watchdog_control <= `WDT_CONTROL_RESET;
		end else if (accept_write) begin
			watchdog_control <= `WDT_CLEARED_VALUE;
		end else if (write_control) begin
			watchdog_control <= sfr_wdata;
		end
	end

	// ****************************************************************
	// prescaler
	// ****************************************************************
	// runs in run and in the pulse, where it times the reset length
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			prescaler <= 11'h000;
		end else if (next_state == st_halted) begin
			prescaler <= 11'h000;
		end else if (accept_write || (state == st_run &&
				next_state == st_pulse)) begin
			prescaler <= 11'h000;
		end else if (tick_bus.osc_tick) begin
			prescaler <= prescaler + 11'h001;
		end
	end

	// ****************************************************************
	// watchdog counter
	// ****************************************************************
	// timeout from a reload is (256 - load) full prescaler wraps
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			watchdog_count <= `WDT_COUNT_RESET;
		end else if (next_state != st_run && !accept_write) begin
			watchdog_count <= `WDT_COUNT_RESET;
		end else if (accept_write) begin
			watchdog_count <= sfr_wdata;
		end else if (wrap) begin
			watchdog_count <= watchdog_count + 8'h01;
		end
	end

	// counts prescaler wraps while the reset pulse is out
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			pulse_wraps <= 4'h0;
		end else if (state != st_pulse) begin
			pulse_wraps <= 4'h0;
		end else if (wrap) begin
			pulse_wraps <= pulse_wraps + 4'h1;
		end
	end

	// ****************************************************************
	// read port
	// ****************************************************************
	// reading never disturbs counting; unmapped addresses read zero
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			sfr_rdata <= 8'h00;
		end else if (sfr_rd && sfr_addr == `WDT_COUNT_ADDR) begin
			sfr_rdata <= watchdog_count;
		end else if (sfr_rd && sfr_addr == `WDT_CONTROL_ADDR) begin
			sfr_rdata <= watchdog_control;
		end else begin
			sfr_rdata <= 8'h00;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	// all from flops; the pin is driven regardless of its own level,
	// so an external low on it cannot hold off the internal reset
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			chip_reset         <= 1'b0;
			rst_pin_out        <= 1'b0;
			rst_pin_oe         <= 1'b0;
			port123_force_high <= 1'b0;
			port0_float        <= 1'b0;
			osc_run            <= 1'b0;
		end else begin
			chip_reset         <= (next_state == st_pulse);
			rst_pin_out        <= (next_state == st_pulse);
			rst_pin_oe         <= (next_state == st_pulse);
			port123_force_high <= (next_state == st_pulse);
			port0_float        <= (next_state == st_pulse);
			osc_run            <= (next_state != st_halted);
		end
	end

	// one-cycle wake on entry to the pulse; only ram survives it
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			powerdown_exit <= 1'b0;
		end else begin
			powerdown_exit <= (state != st_pulse) &&
				(next_state == st_pulse);
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	a_halt_clears: assert property (
		state == st_halted |-> prescaler == 11'h000 &&
			watchdog_count == 8'h00 && !osc_run)
		else $error("halted watchdog not cleared");
	a_run_enabled: assert property (
		state == st_run |-> !is_halt(watchdog_control))
		else $error("running with halt code");
	a_count_step: assert property (
		state == st_run && wrap && !accept_write && !overflow &&
			!write_control
		|=> watchdog_count == $past(watchdog_count) + 8'h01)
		else $error("counter missed a prescaler wrap");
	a_overflow_reset: assert property (
		overflow |=> chip_reset && rst_pin_oe && rst_pin_out)
		else $error("overflow gave no reset");
	a_pulse_end: assert property (
		state == st_pulse && wrap && pulse_wraps == `WDT_PULSE_LAST
		|=> !chip_reset && watchdog_control == `WDT_CONTROL_RESET)
		else $error("reset pulse did not end after 16 wraps");
	a_ports_reset: assert property (
		chip_reset |-> port123_force_high && port0_float)
		else $error("ports not forced during reset");
	a_unlock_write: assert property (
		accept_write |=> watchdog_count == $past(sfr_wdata) &&
			prescaler == 11'h000 && watchdog_control == 8'h00)
		else $error("accepted reload mishandled");
	a_locked_write: assert property (
		write_count && !accept_write && state == st_run && !wrap
		|=> watchdog_count == $past(watchdog_count) &&
			watchdog_control == $past(watchdog_control))
		else $error("locked write changed state");
	a_read_live: assert property (
		sfr_rd && sfr_addr == `WDT_COUNT_ADDR && state == st_run &&
			!(write_control && is_halt(sfr_wdata))
		|=> sfr_rdata == $past(watchdog_count) && state != st_halted)
		else $error("counter read wrong or stopped");
	a_wake_pulse: assert property (
		$rose(chip_reset) |-> powerdown_exit ##1 !powerdown_exit)
		else $error("no power-down wake on watchdog reset");

	c_overflow:    cover property (overflow);
	c_reload:      cover property (accept_write ##1 state == st_run);
	c_locked:      cover property (write_count && !accept_write);
	c_pulse_done:  cover property ($fell(chip_reset));

endmodule : watchdog_timer_unit

// ===== watchdog_timer_unit_bench.sv
`timescale 1ns/1ps
`include "watchdog_regs.svh"
// ****************************************************************
// bench for the watchdog, driven through its register port
// ****************************************************************
module watchdog_timer_unit_bench
	import watchdog_pkg::*;
;
	logic       clk_sys;            // system clock
	logic       reset;              // async reset, high
	logic       wd_osc_raw;         // bench-made watchdog oscillator
	logic [7:0] sfr_addr;           // register address
	logic [7:0] sfr_wdata;          // write data
	logic       sfr_wr;             // write strobe
	logic       sfr_rd;             // read strobe
	logic [7:0] sfr_rdata;          // read data
	logic       osc_run;            // oscillator enable
	logic       chip_reset;         // watchdog reset
	logic       rst_pin_out;        // reset pin level
	logic       rst_pin_oe;         // reset pin enable
	logic       port123_force_high; // ports 1-3 forced
	logic       port0_float;        // port 0 floating
	logic       powerdown_exit;     // power-down exit pulse
	logic [7:0] seen;               // last value read
	int         bad_count   = 0;    // mismatches
	int         checks_done = 0;    // comparisons
	int         osc_rises   = 0;    // rising oscillator edges
	int         exit_pulses = 0;    // cycles with powerdown_exit
	int         base;               // edge count at a reload
	logic [7:0] ctl_vals [5] = '{8'h5a, 8'ha4, 8'h00, 8'hff, 8'h33};

	watchdog_timer_unit watchdog_timer_unit_inst (
		.clk_sys            (clk_sys),
		.reset              (reset),
		.wd_osc_raw         (wd_osc_raw),
		.osc_run            (osc_run),
		.sfr_addr           (sfr_addr),
		.sfr_wdata          (sfr_wdata),
		.sfr_wr             (sfr_wr),
		.sfr_rd             (sfr_rd),
		.sfr_rdata          (sfr_rdata),
		.chip_reset         (chip_reset),
		.rst_pin_out        (rst_pin_out),
		.rst_pin_oe         (rst_pin_oe),
		.port123_force_high (port123_force_high),
		.port0_float        (port0_float),
		.powerdown_exit     (powerdown_exit)
	);

	// ************************************************************
	// clocks
	// ************************************************************
	// 100 ns system clock
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	// oscillator: 8 system cycles a period, still while halted
	// fast enough for the synchroniser, yet keeps a run short
	initial begin
		wd_osc_raw = 1'b0;
		forever begin
			repeat (4) @(posedge clk_sys);
			#1;
			if (osc_run === 1'b1) begin
				wd_osc_raw = ~wd_osc_raw;
				if (wd_osc_raw)
					osc_rises++;
			end else begin
				wd_osc_raw = 1'b0;
			end
		end
	end

	// count cycles of the power-down exit strobe
	always @(posedge clk_sys) begin
		if (powerdown_exit === 1'b1)
			exit_pulses <= exit_pulses + 1;
	end

	// ************************************************************
	// tasks
	// ************************************************************
	// compare one value, report at once
	task check(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("FAIL t=%0t got %h expected %h", $time, got, exp);
		end
	endtask : check

	// verdict and end of run
	task conclude;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : conclude

	// one write cycle; takes effect at the strobe's edge
	task sfr_write(input logic [7:0] addr, input logic [7:0] data);
		@(posedge clk_sys);
		#1;
		sfr_addr  = addr;
		sfr_wdata = data;
		sfr_wr    = 1'b1;
		@(posedge clk_sys);
		#1;
		sfr_wr = 1'b0;
	endtask : sfr_write

	// one read cycle; data is registered at the strobe's edge
	task sfr_read(input logic [7:0] addr, output logic [7:0] data);
		@(posedge clk_sys);
		#1;
		sfr_addr = addr;
		sfr_rd   = 1'b1;
		@(posedge clk_sys);
		#1;
		sfr_rd = 1'b0;
		data   = sfr_rdata;
	endtask : sfr_read

	// wait for an oscillator edge count, bounded; then let the
	// synchroniser and counter settle before looking
	task wait_rises(input int target);
		int i;
		for (i = 0; i < 40000 && osc_rises < target; i++)
			@(posedge clk_sys);
		if (osc_rises < target) begin
			bad_count++;
			$display("FAIL t=%0t oscillator stalled", $time);
			conclude();
		end
		repeat (5) @(posedge clk_sys);
		#1;
	endtask : wait_rises

	// hold reset for ten cycles
	task do_reset;
		reset = 1'b1;
		repeat (10) @(posedge clk_sys);
		#1;
		reset = 1'b0;
	endtask : do_reset

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		sfr_addr  = 8'h00;
		sfr_wdata = 8'h00;
		sfr_wr    = 1'b0;
		sfr_rd    = 1'b0;
		do_reset();
		// reset state and unmapped address
		check({7'h00, osc_run}, 8'h00);
		sfr_read(`WDT_CONTROL_ADDR, seen);
		check(seen, 8'ha5);
		sfr_read(`WDT_COUNT_ADDR, seen);
		check(seen, 8'h00);
		sfr_read(8'h80, seen);
		check(seen, 8'h00);
		// each of five non-halt values runs and reads back
		foreach (ctl_vals[i]) begin
			sfr_write(`WDT_CONTROL_ADDR, ctl_vals[i]);
			sfr_read(`WDT_CONTROL_ADDR, seen);
			check(seen, ctl_vals[i]);
			check({7'h00, osc_run}, 8'h01);
		end
		// locked count write changes nothing
		sfr_write(`WDT_COUNT_ADDR, 8'h80);
		sfr_read(`WDT_COUNT_ADDR, seen);
		check(seen, 8'h00);
		sfr_read(`WDT_CONTROL_ADDR, seen);
		check(seen, 8'h33);
		// halt value stops the oscillator
		sfr_write(`WDT_CONTROL_ADDR, 8'ha5);
		@(posedge clk_sys);
		#1;
		check({7'h00, osc_run}, 8'h00);
		// unlock and load; control clears, watchdog runs on
		sfr_write(`WDT_CONTROL_ADDR, 8'h5a);
		sfr_write(`WDT_COUNT_ADDR, 8'hfe);
		base = osc_rises;
		sfr_read(`WDT_CONTROL_ADDR, seen);
		check(seen, 8'h00);
		sfr_write(`WDT_COUNT_ADDR, 8'h10);
		sfr_read(`WDT_COUNT_ADDR, seen);
		check(seen, 8'hfe);
		check({7'h00, osc_run}, 8'h01);
		// one step per 2048 edges, read on the fly
		wait_rises(base + 2046);
		sfr_read(`WDT_COUNT_ADDR, seen);
		check(seen, 8'hfe);
		wait_rises(base + 2048);
		sfr_read(`WDT_COUNT_ADDR, seen);
		check(seen, 8'hff);
		// reload in time, then let it run out
		sfr_write(`WDT_CONTROL_ADDR, 8'h5a);
		sfr_write(`WDT_COUNT_ADDR, 8'hfd);
		base = osc_rises;
		wait_rises(base + 4096);
		sfr_read(`WDT_COUNT_ADDR, seen);
		check(seen, 8'hff);
		wait_rises(base + 6142);
		check({7'h00, chip_reset}, 8'h00);
		wait_rises(base + 6144);
		check({7'h00, chip_reset}, 8'h01);
		check({6'h00, rst_pin_oe, rst_pin_out}, 8'h03);
		check({6'h00, port123_force_high, port0_float}, 8'h03);
		check(exit_pulses[7:0], 8'h01);
		check({7'h00, osc_run}, 8'h01);
		// pulse still standing well into its length
		wait_rises(osc_rises + 1000);
		check({7'h00, chip_reset}, 8'h01);
		check(exit_pulses[7:0], 8'h01);
		// writes are refused while the reset pulse is out
		sfr_write(`WDT_CONTROL_ADDR, 8'h5a);
		sfr_read(`WDT_CONTROL_ADDR, seen);
		check(seen, 8'ha5);
		// external reset brings back the halted state
		do_reset();
		check({7'h00, chip_reset}, 8'h00);
		sfr_read(`WDT_CONTROL_ADDR, seen);
		check(seen, 8'ha5);
		conclude();
	end
endmodule : watchdog_timer_unit_bench
